// [pkg/dea_pkg.sv]
/*
 * Shared constants for the data EEPROM access sequencer: register map, control
 * field layout, operation codes, unlock keys, cycle time and state types.
 * Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package dea_pkg;

    // ----------------------------------------------------------------------
    // Sizes and address window
    // ----------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int MEM_WORDS = 512;
    localparam int MEM_AW = 9;
    localparam int BLOCK_WORDS = 16;
    localparam logic [23:0] EE_FIRST = 24'h7F_FC00;
    localparam logic [23:0] EE_LAST = 24'h7F_FFFE;

    // ----------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
    localparam logic [7:0] OFF_ADDR_UPPER = 8'h08;
    localparam logic [7:0] OFF_KEY = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // ----------------------------------------------------------------------
    // Control fields, codes, keys, reset values
    // ----------------------------------------------------------------------
    localparam int BIT_START = 15;
    localparam int BIT_WEN = 14;
    localparam int BIT_WERR = 13;
    localparam int BIT_DONE = 0;
    localparam int OP_W = 7;
    localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
    localparam logic [6:0] OP_WORD_ERASE = 7'h44;
    localparam logic [6:0] OP_WORD_PROG = 7'h04;
    localparam logic [6:0] OP_BLOCK_PROG = 7'h0A;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int WRITE_TIME_US = 2000;
    localparam int CLK_FREQ_MHZ = 10;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} dea_key_e;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_COMMIT} dea_state_e;

endpackage : dea_pkg

// [design/dea_word_ram.sv]
/*
 * Word-wide storage array for the data EEPROM cells.
 * Assumes one write and one read per clock; read data come out of a register.
 */
`timescale 1ns/1ns
module dea_word_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic aclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] cells [DEPTH];

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end
endmodule : dea_word_ram

// [design/dea_sequencer.sv]
/*
 * Data EEPROM access sequencer: AXI4-Lite control registers, unlock key,
 * write latches, background erase/program timer and table read/write port.
 * Assumes the core issues table accesses as one-cycle strobes on aclk and
 * that the reset event inputs come from outside the clock domain.
 */
// Contract
// - Single-word and sixteen-word block operations
// - EEPROM window 0x7FFC00 to 0x7FFFFE
// - Target address is upper joined with low
// - Write or erase lasts two milliseconds
// - Cycle runs in background, core not stalled
// - Reads during a cycle are undefined
// - Start bit software-set only, hardware-cleared
// - Write enable cleared at power-up
// - Reset-aborted cycle sets error, keeps address
// - Completion sets done flag until cleared
// - Start needs 0x55 then 0xAA keys
// - Start needs enable set beforehand
// - Dropping enable never stops running cycle
// - Hardware never clears write enable
// - Table write loads latch, captures address
// - Table read returns addressed word
// - Block write fills sixteen latches first
`timescale 1ns/1ns
module dea_sequencer #(
    parameter int WRITE_CYCLES = dea_pkg::WRITE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic tbl_rd,
    input wire logic tbl_wr,
    input wire logic [23:0] tbl_addr,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    input wire logic master_clear_reset,
    input wire logic watchdog_timer_reset,
    output logic nvm_done_flag,
    output logic write_busy
);
    localparam logic [31:0] LAST_COUNT = 32'(WRITE_CYCLES - 1);

    // ----------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------
    dea_pkg::dea_state_e state, next_state;
    dea_pkg::dea_key_e key_q, next_key_q;
    logic [6:0] op_code, next_op_code;
    logic [6:0] run_op, next_run_op;
    logic write_enable_bit, next_write_enable_bit;
    logic write_error_flag, next_write_error_flag;
    logic next_nvm_done_flag;
    logic [15:0] nvm_address_low, next_nvm_address_low;
    logic [7:0] nvm_address_upper, next_nvm_address_upper;
    logic [8:0] run_index, next_run_index;
    logic [3:0] word_cnt, next_word_cnt;
    logic [31:0] timer_q, next_timer_q;
    logic [15:0] latch [dea_pkg::BLOCK_WORDS];
    logic master_clear_reset_s1, master_clear_reset_s2, wdt_s1, wdt_s2;
    logic next_bvalid, next_rvalid, next_tbl_rvalid, rd_in_range, next_rd_in_range;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // ----------------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------------
    logic wr_fire, rd_fire, ctl_wr, key_wr, stat_wr, low_wr, up_wr, start_req, abort_evt;
    logic [15:0] wmask, wword;
    logic [23:0] target;
    logic tbl_in_range, block_op, erase_op, last_word, mem_we;
    logic [8:0] mem_waddr;
    logic [15:0] mem_wdata, mem_q;

    assign wr_fire = awvalid && wvalid && !bvalid;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign rd_fire = arvalid && !rvalid;
    assign arready = rd_fire;
    assign wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
    assign wword = wdata[15:0];
    assign ctl_wr = wr_fire && awaddr == dea_pkg::OFF_CONTROL;
    assign key_wr = wr_fire && awaddr == dea_pkg::OFF_KEY && wstrb[0];
    assign stat_wr = wr_fire && awaddr == dea_pkg::OFF_STATUS && wstrb[0];
    assign low_wr = wr_fire && awaddr == dea_pkg::OFF_ADDR_LOW;
    assign up_wr = wr_fire && awaddr == dea_pkg::OFF_ADDR_UPPER && wstrb[0];
    assign target = {nvm_address_upper, nvm_address_low};
    assign tbl_in_range = tbl_addr >= dea_pkg::EE_FIRST && tbl_addr <= dea_pkg::EE_LAST;
    // Enable is judged on its value before this write, so one write cannot set both
    assign start_req = ctl_wr && wstrb[1] && wdata[dea_pkg::BIT_START]
        && key_q == dea_pkg::KEY_ARMED && write_enable_bit && state == dea_pkg::ST_IDLE;
    assign abort_evt = master_clear_reset_s2 || wdt_s2;
    assign block_op = run_op == dea_pkg::OP_BLOCK_ERASE || run_op == dea_pkg::OP_BLOCK_PROG;
    assign erase_op = run_op == dea_pkg::OP_BLOCK_ERASE || run_op == dea_pkg::OP_WORD_ERASE;
    assign last_word = !block_op || word_cnt == 4'(dea_pkg::BLOCK_WORDS - 1);
    assign write_busy = state != dea_pkg::ST_IDLE;

    // ----------------------------------------------------------------------
    // Reset event synchronisers
    // ----------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_clear_reset_s1 <= 1'b0;
            master_clear_reset_s2 <= 1'b0;
            wdt_s1 <= 1'b0;
            wdt_s2 <= 1'b0;
        end else begin
            master_clear_reset_s1 <= master_clear_reset;
            master_clear_reset_s2 <= master_clear_reset_s1;
            wdt_s1 <= watchdog_timer_reset;
            wdt_s2 <= wdt_s1;
        end
    end

    // ----------------------------------------------------------------------
    // Control, key and cycle sequencing
    // ----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_key_q = key_q;
        next_op_code = op_code;
        next_run_op = run_op;
        next_write_enable_bit = write_enable_bit;
        next_write_error_flag = write_error_flag;
        next_nvm_done_flag = nvm_done_flag;
        next_nvm_address_low = nvm_address_low;
        next_nvm_address_upper = nvm_address_upper;
        next_run_index = run_index;
        next_word_cnt = word_cnt;
        next_timer_q = timer_q;
        mem_we = 1'b0;
        mem_waddr = run_index;
        mem_wdata = dea_pkg::ERASED_WORD;
        if (key_wr) begin
            if (wword[7:0] == dea_pkg::KEY_FIRST) begin
                next_key_q = dea_pkg::KEY_HALF;
            end else if (wword[7:0] == dea_pkg::KEY_SECOND && key_q == dea_pkg::KEY_HALF) begin
                next_key_q = dea_pkg::KEY_ARMED;
            end else begin
                next_key_q = dea_pkg::KEY_IDLE;
            end
        end
        if (ctl_wr) begin
            // Any control write consumes the key so each start needs a fresh unlock
            next_key_q = dea_pkg::KEY_IDLE;
            if (wstrb[0]) begin
                next_op_code = wword[dea_pkg::OP_W-1:0];
            end
            if (wstrb[1]) begin
                next_write_enable_bit = wword[dea_pkg::BIT_WEN];
                next_write_error_flag = wword[dea_pkg::BIT_WERR];
            end
        end
        if (stat_wr && wword[dea_pkg::BIT_DONE]) begin
            next_nvm_done_flag = 1'b0;
        end
        if (low_wr) begin
            next_nvm_address_low = (nvm_address_low & ~wmask) | (wword & wmask);
        end
        if (up_wr) begin
            next_nvm_address_upper = wword[7:0];
        end
        if (tbl_wr && tbl_in_range) begin
            next_nvm_address_low = tbl_addr[15:0];
            next_nvm_address_upper = tbl_addr[23:16];
        end
        unique case (state)
            dea_pkg::ST_IDLE: begin
                if (start_req) begin
                    next_state = dea_pkg::ST_WAIT;
                    next_timer_q = LAST_COUNT;
                    next_run_op = next_op_code;
                    next_run_index = target[9:1];
                    next_word_cnt = 4'h0;
                end
            end
            dea_pkg::ST_WAIT: begin
                if (timer_q == 32'h0000_0000) begin
                    next_state = dea_pkg::ST_COMMIT;
                end else begin
                    next_timer_q = timer_q - 32'h0000_0001;
                end
            end
            dea_pkg::ST_COMMIT: begin
                mem_we = 1'b1;
                mem_waddr = block_op ? {run_index[8:4], word_cnt} : run_index;
                if (!erase_op) begin
                    mem_wdata = block_op ? latch[word_cnt] : latch[run_index[3:0]];
                end
                next_word_cnt = word_cnt + 4'h1;
                if (last_word) begin
                    next_state = dea_pkg::ST_IDLE;
                    next_nvm_done_flag = 1'b1;
                end
            end
        endcase
        if (abort_evt && state != dea_pkg::ST_IDLE) begin
            next_state = dea_pkg::ST_IDLE;
            next_write_error_flag = 1'b1;
            mem_we = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= dea_pkg::ST_IDLE;
            key_q <= dea_pkg::KEY_IDLE;
            op_code <= 7'h00;
            run_op <= 7'h00;
            write_enable_bit <= 1'b0;
            write_error_flag <= 1'b0;
            nvm_done_flag <= 1'b0;
            nvm_address_low <= 16'h0000;
            nvm_address_upper <= 8'h00;
            run_index <= 9'h000;
            word_cnt <= 4'h0;
            timer_q <= 32'h0000_0000;
        end else begin
            state <= next_state;
            key_q <= next_key_q;
            op_code <= next_op_code;
            run_op <= next_run_op;
            write_enable_bit <= next_write_enable_bit;
            write_error_flag <= next_write_error_flag;
            nvm_done_flag <= next_nvm_done_flag;
            nvm_address_low <= next_nvm_address_low;
            nvm_address_upper <= next_nvm_address_upper;
            run_index <= next_run_index;
            word_cnt <= next_word_cnt;
            timer_q <= next_timer_q;
        end
    end

    // ----------------------------------------------------------------------
    // Write latches, one per block word
    // ----------------------------------------------------------------------
    generate
        for (genvar i = 0; i < dea_pkg::BLOCK_WORDS; i++) begin : g_latch
            logic [15:0] next_latch;
            always_comb begin
                next_latch = latch[i];
                if (tbl_wr && tbl_in_range && tbl_addr[4:1] == 4'(i)) begin
                    next_latch = tbl_wdata;
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    latch[i] <= dea_pkg::ZERO_WORD;
                end else begin
                    latch[i] <= next_latch;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------------
    // Cell array and table read path
    // ----------------------------------------------------------------------
    dea_word_ram #(
        .WIDTH(dea_pkg::DATA_W),
        .DEPTH(dea_pkg::MEM_WORDS),
        .AW(dea_pkg::MEM_AW)
    ) u_cells (
        .aclk(aclk),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_en(tbl_rd),
        .rd_addr(tbl_addr[9:1]),
        .rd_data(mem_q)
    );

    // Reads are served even mid-cycle; the word may be stale or half written
    assign tbl_rdata = rd_in_range ? mem_q : dea_pkg::ZERO_WORD;
    assign next_tbl_rvalid = tbl_rd;
    assign next_rd_in_range = tbl_rd ? tbl_in_range : rd_in_range;

    // ----------------------------------------------------------------------
    // AXI4-Lite responses
    // ----------------------------------------------------------------------
    always_comb begin
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = (ctl_wr || low_wr || awaddr == dea_pkg::OFF_ADDR_UPPER
                || awaddr == dea_pkg::OFF_KEY || awaddr == dea_pkg::OFF_STATUS)
                ? dea_pkg::RESP_OKAY : dea_pkg::RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = dea_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (araddr)
                dea_pkg::OFF_CONTROL: next_rdata = {16'h0000, write_busy, write_enable_bit,
                    write_error_flag, 6'h00, op_code};
                dea_pkg::OFF_ADDR_LOW: next_rdata = {16'h0000, nvm_address_low};
                dea_pkg::OFF_ADDR_UPPER: next_rdata = {24'h00_0000, nvm_address_upper};
                dea_pkg::OFF_KEY: next_rdata = 32'h0000_0000;
                dea_pkg::OFF_STATUS: next_rdata = {31'h0000_0000, nvm_done_flag};
                default: next_rresp = dea_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= dea_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= dea_pkg::RESP_OKAY;
            rdata <= 32'h0000_0000;
            tbl_rvalid <= 1'b0;
            rd_in_range <= 1'b0;
        end else begin
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            tbl_rvalid <= next_tbl_rvalid;
            rd_in_range <= next_rd_in_range;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_start_key;
        $rose(write_busy) |-> $past(key_q) == dea_pkg::KEY_ARMED;
    endproperty
    a_start_key: assert property (p_start_key) else $error("start without unlock");

    property p_start_wen;
        $rose(write_busy) |-> $past(write_enable_bit) && $past(ctl_wr);
    endproperty
    a_start_wen: assert property (p_start_wen) else $error("start without enable");

    property p_wen_hold;
        write_enable_bit && !ctl_wr |=> write_enable_bit;
    endproperty
    a_wen_hold: assert property (p_wen_hold) else $error("enable cleared by hardware");

    property p_done_sticky;
        nvm_done_flag && !stat_wr |=> nvm_done_flag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_timer_load;
        $rose(write_busy) |-> state == dea_pkg::ST_WAIT && timer_q == LAST_COUNT;
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("cycle timer not loaded");

    property p_wait_runs;
        state == dea_pkg::ST_WAIT && !abort_evt |=> write_busy;
    endproperty
    a_wait_runs: assert property (p_wait_runs) else $error("cycle ended early");

    property p_abort;
        write_busy && abort_evt |=> !write_busy && write_error_flag
            && target == $past(target);
    endproperty
    a_abort: assert property (p_abort) else $error("reset abort mishandled");

    property p_tbl_addr;
        tbl_wr && tbl_in_range |=> target == $past(tbl_addr);
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address not captured");

    property p_tbl_read;
        tbl_rd |=> tbl_rvalid ##1 !tbl_rvalid || $past(tbl_rd);
    endproperty
    a_tbl_read: assert property (p_tbl_read) else $error("table read not answered");

    property p_key_discard;
        key_wr && wword[7:0] != dea_pkg::KEY_FIRST && wword[7:0] != dea_pkg::KEY_SECOND
            |=> key_q == dea_pkg::KEY_IDLE;
    endproperty
    a_key_discard: assert property (p_key_discard) else $error("stray key kept");

endmodule : dea_sequencer

// [bench/dea_core_model.sv]
/*
 * Core-side model of the table access path: one-cycle read and write strobes.
 * Assumes its tasks are called just after a rising edge of aclk.
 */
`timescale 1ns/1ns
module dea_core_model (
    input wire logic aclk,
    output logic tbl_rd,
    output logic tbl_wr,
    output logic [23:0] tbl_addr,
    output logic [15:0] tbl_wdata,
    input wire logic [15:0] tbl_rdata,
    input wire logic tbl_rvalid
);
    initial begin
        tbl_rd = 1'b0;
        tbl_wr = 1'b0;
        tbl_addr = 24'h00_0000;
        tbl_wdata = 16'h0000;
    end
    // Back-to-back latch loads; data line turns to garbage once released
    task tw(input logic [23:0] a, input logic [15:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            tbl_wr <= 1'b1;
            tbl_addr <= a + 24'(2 * i);
            tbl_wdata <= d + 16'(i);
            @(posedge aclk);
        end
        tbl_wr <= 1'b0;
        tbl_wdata <= ~tbl_wdata;
    endtask : tw
    task tr(input logic [23:0] a, output logic [15:0] d, output logic v);
        tbl_rd <= 1'b1;
        tbl_addr <= a;
        @(posedge aclk);
        tbl_rd <= 1'b0;
        @(posedge aclk);
        d = tbl_rdata;
        v = tbl_rvalid;
    endtask : tr
endmodule : dea_core_model

// [bench/tb_top.sv]
/*
 * Self-checking bench for the data EEPROM access sequencer.
 * Assumes the cycle time parameter is shortened to WC core cycles.
 */
`timescale 1ns/1ns
module tb_top;
    localparam int WC = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, v;
    logic master_clear_reset = 1'b0, watchdog_timer_reset = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tbl_rd, tbl_wr, tbl_rvalid;
    logic nvm_done_flag, write_busy;
    logic [1:0] bresp, rresp, lr;
    logic [23:0] tbl_addr;
    logic [15:0] tbl_wdata, tbl_rdata, td;
    int err_count = 0, n_tests = 0;
    always #50 aclk = ~aclk;
    dea_sequencer #(.WRITE_CYCLES(WC)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(1'b1), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr),
        .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
        .tbl_rvalid(tbl_rvalid), .master_clear_reset(master_clear_reset),
        .watchdog_timer_reset(watchdog_timer_reset), .nvm_done_flag(nvm_done_flag),
        .write_busy(write_busy));
    dea_core_model u_core (.aclk(aclk), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr),
        .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
        .tbl_rvalid(tbl_rvalid));
    // ----------------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------------
    task close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic await(ref logic s, input logic x);
        int i;
        i = 0;
        do begin
            @(posedge aclk);
            i++;
        end while (s !== x && i < 60);
        if (i >= 60) begin
            err_count++;
            close_out();
        end
    endtask : await
    task axw(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        await(awready, 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        await(bvalid, 1'b1);
        lr = bresp;
    endtask : axw
    task axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        await(arready, 1'b1);
        arvalid <= 1'b0;
        await(rvalid, 1'b1);
        rd = rdata;
        lr = rresp;
    endtask : axr
    task op(input logic [31:0] c);
        axw(8'h00, c);
        axw(8'h0C, 32'h0000_0055);
        axw(8'h0C, 32'h0000_00AA);
        axw(8'h00, c | 32'h0000_8000);
        chk(write_busy, 1);
    endtask : op
    task fin(input logic [31:0] e, input int lo);
        int n;
        n = 0;
        while (write_busy === 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
        end
        chk(n >= lo && n <= WC + 17, 1);
        chk(nvm_done_flag, 1);
        axr(8'h00);
        chk(rd, e);
        axr(8'h10);
        chk(rd, 1);
        axw(8'h10, 32'h0000_0001);
        chk(nvm_done_flag, 0);
    endtask : fin
    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task s_reset;
        axr(8'h00);
        chk(rd, 0);
        axr(8'h14);
        chk(rd, 0);
        chk(lr, 2);
        axw(8'h14, 32'h0000_0001);
        chk(lr, 2);
    endtask : s_reset
    task s_guard;
        axw(8'h00, 32'h0000_0044);
        axw(8'h0C, 32'h0000_0055);
        axw(8'h0C, 32'h0000_00AA);
        axw(8'h00, 32'h0000_C044);
        chk(write_busy, 0);
        axw(8'h00, 32'h0000_4044);
        axw(8'h0C, 32'h0000_0055);
        axw(8'h0C, 32'h0000_0012);
        axw(8'h0C, 32'h0000_00AA);
        axw(8'h00, 32'h0000_C044);
        chk(write_busy, 0);
        axw(8'h00, 32'h0000_C044);
        chk(write_busy, 0);
    endtask : s_guard
    task s_word;
        u_core.tw(24'h7F_FC20, 16'h1234, 1);
        axr(8'h04);
        chk(rd, 32'h0000_FC20);
        op(32'h0000_4044);
        axw(8'h00, 32'h0000_0044);
        chk(write_busy, 1);
        fin(32'h0000_0044, WC - 2);
        u_core.tr(24'h7F_FC20, td, v);
        chk({v, td}, {1'b1, 16'hFFFF});
        op(32'h0000_4004);
        fin(32'h0000_4004, WC);
        u_core.tr(24'h7F_FC20, td, v);
        chk({v, td}, {1'b1, 16'h1234});
    endtask : s_word
    task s_block;
        axw(8'h04, 32'h0000_FC40);
        axw(8'h08, 32'h0000_007F);
        op(32'h0000_4045);
        fin(32'h0000_4045, WC);
        u_core.tr(24'h7F_FC46, td, v);
        chk({v, td}, {1'b1, 16'hFFFF});
        u_core.tw(24'h7F_FC40, 16'hA000, 16);
        op(32'h0000_400A);
        fin(32'h0000_400A, WC);
        for (int i = 0; i < 16; i++) begin
            u_core.tr(24'h7F_FC40 + 24'(2 * i), td, v);
            chk(td, 16'hA000 + 16'(i));
        end
        u_core.tw(24'h00_0042, 16'h5555, 1);
        axr(8'h04);
        chk(rd, 32'h0000_FC5E);
        u_core.tr(24'h00_0040, td, v);
        chk({v, td}, {1'b1, 16'h0000});
    endtask : s_block
    task s_abort;
        for (int s = 0; s < 2; s++) begin
            op(32'h0000_4004);
            master_clear_reset <= (s == 0);
            watchdog_timer_reset <= (s == 1);
            repeat (3) @(posedge aclk);
            master_clear_reset <= 1'b0;
            watchdog_timer_reset <= 1'b0;
            await(write_busy, 1'b0);
            axr(8'h00);
            chk(rd, 32'h0000_6004);
            axr(8'h04);
            chk(rd, 32'h0000_FC5E);
            axw(8'h00, 32'h0000_4004);
        end
    endtask : s_abort
    initial begin
        #2_000_000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_reset();
        s_guard();
        s_word();
        s_block();
        s_abort();
        close_out();
    end
endmodule : tb_top
